// ### hw/meas_ctrl_defs.svh
/*
  Constants of the measurement sequencer: timing figures, counts, widths.
  Assumes a 100 MHz clock; included by package and modules.
*/
// What this block does
// - Stop ends a start delay at once or lets a measurement finish, then sleeps
// - Sleeping device self-wakes every second
// - Bus activity wakes the device
// - Results stay readable after stopping
// - Measurement starts one minute after start
// - Measurement sequence lasts about twenty seconds
// - PWM duty cycle encodes concentration
// - Alarm mode switches output on during alarm
`ifndef MEAS_CTRL_DEFS_SVH
`define MEAS_CTRL_DEFS_SVH
`define CLK_HZ          100000000
`define START_DELAY_S   60
`define MEAS_TIME_S     20
`define WAKE_PERIOD_S   1
`define CONC_W          16
`define TEMP_W          16
`define PWM_W           8
`define TICK_CYCLES     100000
`define RES_RESET       16'h0000
`endif

// ### hw/meas_ctrl_pkg.sv
/*
  Types of the measurement sequencer.
  Assumes the defs header is on the include path.
*/
`include "meas_ctrl_defs.svh"
package meas_ctrl_pkg;
  typedef enum logic [2:0] {ST_SLEEP, ST_WAKE, ST_DELAY, ST_MEAS,
                            ST_IDLE} seq_state_t;
  typedef struct packed
  {
    logic [`CONC_W-1:0] conc;
    logic [`TEMP_W-1:0] temp;
  } result_t;
endpackage

// ### hw/oc_output.sv
/*
  Open-collector output stage: alarm level or PWM from concentration.
  Assumes conc is stable for a whole PWM period or more.
*/
`timescale 1ns/1ps
`default_nettype none
`include "meas_ctrl_defs.svh"
module oc_output
#(
  parameter int CONC_W = `CONC_W,
  parameter int PWM_W  = `PWM_W
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              pwm_mode,
  input  wire logic              alarm,
  input  wire logic [CONC_W-1:0] conc,
  // Pin, low side switch
  output logic                   drive_low
);
  initial if (PWM_W > CONC_W) $error("PWM_W wider than CONC_W");

  logic [PWM_W-1:0] phase;
  // Duty taken from top bits of concentration; fine scaling left out
  wire  [PWM_W-1:0] duty = conc[CONC_W-1 -: PWM_W];
  wire              pwm_on = phase < duty;
  wire              next_drive = pwm_mode ? pwm_on : alarm;

  ////////////////////////////////////////////////////////////////////////
  // Free running phase and registered pin drive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase     <= '0;
      drive_low <= 1'b0;
    end
    else
    begin
      phase     <= phase + 1'b1;
      drive_low <= next_drive;
    end
  end

  property p_alarm_drive;
    @(posedge clk) disable iff (!rst_n)
    (!pwm_mode && alarm) ##1 (!pwm_mode) |-> drive_low;
  endproperty
  a_alarm_drive: assert property (p_alarm_drive)
    else $error("alarm not shown on output");

  property p_pwm_duty;
    @(posedge clk) disable iff (!rst_n)
    pwm_mode |=> drive_low == $past(pwm_on);
  endproperty
  a_pwm_duty: assert property (p_pwm_duty)
    else $error("pwm output does not follow duty");
endmodule
`default_nettype wire

// ### hw/meas_ctrl.sv
/*
  Measurement sequencer: start delay, measurement, stop, sleep and wake.
  Assumes inputs synchronous to clk; the sensing front end reports
  results on meas_done and the bus engine flags bus_activity.
*/
`timescale 1ns/1ps
`default_nettype none
`include "meas_ctrl_defs.svh"
module meas_ctrl
  import meas_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES   = `TICK_CYCLES,
  parameter int START_DELAY_S = `START_DELAY_S,
  parameter int MEAS_TIME_S   = `MEAS_TIME_S,
  parameter int WAKE_PERIOD_S = `WAKE_PERIOD_S,
  parameter int TICKS_PER_S   = 1000
)
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Host commands, one-cycle pulses
  input  wire logic    start_cmd,
  input  wire logic    stop_cmd,
  input  wire logic    bus_activity,
  // Jumper and configuration
  input  wire logic    start_jumper,
  input  wire logic    pwm_mode,
  input  wire logic    alarm,
  // Front end
  input  wire logic    meas_done,
  input  wire result_t meas_result,
  // Status and results
  output logic         measuring,
  output logic         scl_hold,
  output logic         asleep,
  output logic         wake_pulse,
  output logic         jumper_seen,
  output result_t      last_result,
  // Open-collector pin
  output logic         open_collector_output_oe,
  output logic         open_collector_output_out
);
  // A one-tick wake period would let a wake land on the re-entry cycle
  initial if (TICK_CYCLES < 1 || TICKS_PER_S < 1 || MEAS_TIME_S < 1 ||
              WAKE_PERIOD_S * TICKS_PER_S < 2)
    $error("timing parameters out of range");

  localparam int START_TICKS = START_DELAY_S * TICKS_PER_S;
  localparam int MEAS_TICKS  = MEAS_TIME_S * TICKS_PER_S;
  localparam int WAKE_TICKS  = WAKE_PERIOD_S * TICKS_PER_S;

  seq_state_t  state;
  seq_state_t  next_state;
  logic [31:0] div;
  logic [31:0] ticks;
  logic        run;
  logic        jumper_prev;
  logic        bus_late;
  logic        got_result;

  ////////////////////////////////////////////////////////////////////////
  // Tick divider: one-cycle enable, slow time counts in ticks
  wire tick = (div == 32'(TICK_CYCLES - 1));
  wire jumper_set = start_jumper && !jumper_prev;
  wire start_req = start_cmd || jumper_set;
  wire delay_over = tick && (ticks == 32'(START_TICKS - 1));
  // A result pulse early in the sequence is kept until the time is up
  wire meas_over = tick && (ticks >= 32'(MEAS_TICKS - 1)) &&
                   (meas_done || got_result);
  wire wake_due = tick && (ticks == 32'(WAKE_TICKS - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div <= '0;
    else
      div <= tick ? 32'h0000_0000 : div + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state; a stop ends a delay at once, in measurement it only clears run and the measurement completes first
  always_comb
  begin
    next_state = state;
    case (state)
      ST_SLEEP:
        // Late activity covers a pulse met during the wake cycle
        if (bus_activity || bus_late || start_req || run)
          next_state = ST_IDLE;
        else if (wake_due) next_state = ST_WAKE;
      ST_WAKE:
        next_state = ST_SLEEP; // Housekeeping done in one cycle
      ST_IDLE:
        // A start caught while asleep left run set: open the delay now
        if (start_req || run) next_state = ST_DELAY;
        else if (!bus_activity) next_state = ST_SLEEP;
      ST_DELAY:
        if (stop_cmd) next_state = ST_IDLE;
        else if (delay_over) next_state = ST_MEAS;
      ST_MEAS:
        if (meas_over) next_state = run ? ST_DELAY : ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State, tick count, run flag and result store
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= ST_IDLE;
      ticks       <= '0;
      run         <= 1'b0;
      jumper_prev <= 1'b0;
      bus_late    <= 1'b0;
      got_result  <= 1'b0;
      jumper_seen <= 1'b0;
      last_result <= '0;
    end
    else
    begin
      state       <= next_state;
      jumper_prev <= start_jumper;
      bus_late    <= bus_activity;
      // Result flag lives for one measurement sequence only
      if (next_state != state)
        got_result <= 1'b0;
      else if (state == ST_MEAS && meas_done)
        got_result <= 1'b1;
      if (next_state != state)
        ticks <= '0;
      else if (tick)
        ticks <= ticks + 32'h0000_0001;
      // Start wins over a same-cycle stop
      if (start_req)
        run <= 1'b1;
      else if (stop_cmd)
        run <= 1'b0;
      if (state == ST_WAKE)
        jumper_seen <= start_jumper;
      // Results held regardless of run, readable when stopped
      if (state == ST_MEAS && meas_done)
        last_result <= meas_result;
    end
  end

  // Clock stretch while measuring; host must wait it out
  assign measuring  = (state == ST_MEAS);
  assign scl_hold   = measuring;
  assign asleep     = (state == ST_SLEEP) || (state == ST_WAKE);
  assign wake_pulse = (state == ST_WAKE);

  ////////////////////////////////////////////////////////////////////////
  // Open-collector output stage
  logic drive_low;
  oc_output u_oc
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .pwm_mode  (pwm_mode),
    .alarm     (alarm),
    .conc      (last_result.conc),
    .drive_low (drive_low)
  );
  // Open collector only ever pulls low
  assign open_collector_output_oe  = drive_low;
  assign open_collector_output_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_meas_end;
    measuring && meas_over;
  endsequence

  property p_stop_finishes;
    @(posedge clk) disable iff (!rst_n)
    (measuring && stop_cmd && !start_req) |=> measuring || state == ST_IDLE;
  endproperty
  a_stop_finishes: assert property (p_stop_finishes)
    else $error("measurement cut short by stop");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_SLEEP && wake_due && !bus_activity && !start_req)
      |=> wake_pulse ##1 state == ST_SLEEP;
  endproperty
  a_wake: assert property (p_wake)
    else $error("periodic wake missing");

  property p_bus_wake;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_SLEEP && bus_activity) |=> !asleep;
  endproperty
  a_bus_wake: assert property (p_bus_wake)
    else $error("bus activity did not wake");

  property p_result_kept;
    @(posedge clk) disable iff (!rst_n)
    !measuring |=> last_result == $past(last_result);
  endproperty
  a_result_kept: assert property (p_result_kept)
    else $error("result changed while stopped");

  property p_delay_to_meas;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_DELAY && delay_over && !stop_cmd) |=> measuring;
  endproperty
  a_delay_to_meas: assert property (p_delay_to_meas)
    else $error("measurement did not start after delay");

  property p_meas_ends;
    @(posedge clk) disable iff (!rst_n)
    s_meas_end |=> !measuring;
  endproperty
  a_meas_ends: assert property (p_meas_ends)
    else $error("measurement did not end");

  property p_meas_len;
    @(posedge clk) disable iff (!rst_n)
    (measuring && !$past(measuring)) |-> ticks == 32'h0000_0000;
  endproperty
  a_meas_len: assert property (p_meas_len)
    else $error("measurement timer not restarted");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    scl_hold |-> measuring;
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock held outside measurement");
endmodule
`default_nettype wire

// ### test/host_model.sv
/*
  Host controller model: start, stop and bus activity pulses.
  Assumes the sequencer's clock; drives just after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock
  input  wire logic clk,
  // Bus side
  input  wire logic scl_hold,
  output logic      start_cmd,
  output logic      stop_cmd,
  output logic      bus_activity
);
  initial
  begin
    start_cmd    = 1'b0;
    stop_cmd     = 1'b0;
    bus_activity = 1'b0;
  end

  // Stop only when the bench asks, after fresh data was read
  // A command cannot pass while the clock line is held
  task automatic pulse(input logic is_stop);
    while (scl_hold)
      @(posedge clk);
    stop_cmd  <= is_stop;
    start_cmd <= !is_stop;
    @(posedge clk);
    stop_cmd  <= 1'b0;
    start_cmd <= 1'b0;
  endtask

  // Stop that skips the hold wait; a stop landing inside measurement
  // must still let the sequence run to its end
  task automatic stop_early();
    stop_cmd <= 1'b1;
    @(posedge clk);
    stop_cmd <= 1'b0;
  endtask

  // One cycle of line activity
  task automatic touch();
    bus_activity <= 1'b1;
    @(posedge clk);
    bus_activity <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb_gas_sensor_measure_control.sv
/*
  Bench of the measurement sequencer with shortened ticks.
  Assumes TICK_CYCLES 2 and 4 ticks a second: delay 480 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "meas_ctrl_defs.svh"
module tb_gas_sensor_measure_control;
  import meas_ctrl_pkg::*;
  localparam int TB_TICK   = 2;
  localparam int TB_TPS    = 4;
  localparam int DELAY_CYC = `START_DELAY_S * TB_TPS * TB_TICK;
  localparam int MEAS_CYC  = `MEAS_TIME_S * TB_TPS * TB_TICK;
  logic    clk, rst_n, start_cmd, stop_cmd, bus_activity, start_jumper;
  logic    pwm_mode, alarm, meas_done, measuring, scl_hold, asleep;
  logic    wake_pulse, jumper_seen, oc_oe, oc_out;
  result_t meas_result, last_result;
  int      fail_count, cmp_count, n;

  meas_ctrl #(.TICK_CYCLES(TB_TICK), .TICKS_PER_S(TB_TPS)) u_meas_ctrl
  (
    .clk(clk), .rst_n(rst_n), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .bus_activity(bus_activity), .start_jumper(start_jumper),
    .pwm_mode(pwm_mode), .alarm(alarm), .meas_done(meas_done),
    .meas_result(meas_result), .measuring(measuring), .scl_hold(scl_hold),
    .asleep(asleep), .wake_pulse(wake_pulse), .jumper_seen(jumper_seen),
    .last_result(last_result), .open_collector_output_oe(oc_oe),
    .open_collector_output_out(oc_out)
  );

  host_model u_host
  (
    .clk(clk), .scl_hold(scl_hold), .start_cmd(start_cmd),
    .stop_cmd(stop_cmd), .bus_activity(bus_activity)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock, reset and comparison
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Delay is one minute give or take divider phase and the wake path
  function automatic logic near(input int seen, input int exp);
    return seen >= exp - 1 && seen <= exp + 4;
  endfunction

  // Count falling edges until measuring shows the wanted level
  task automatic wait_meas(input logic level, output int cycles);
    cycles = 0;
    while (measuring !== level && cycles < 2000)
    begin
      @(negedge clk);
      cycles++;
    end
  endtask

  // Asleep after reset, periodic wake, bus wake
  task automatic t_sleep();
    repeat (3) @(negedge clk);
    check("asleep", asleep, 1);
    check("pin level", oc_out, 0);
    n = 0;
    repeat (3 * TB_TPS * TB_TICK)
    begin
      @(negedge clk);
      n += wake_pulse;
    end
    check("wakes", n, 3);
    check("jumper low", jumper_seen, 0);
    @(posedge clk);
    u_host.touch();
    @(negedge clk);
    check("awake", asleep, 0);
  endtask

  // Start command while asleep, full sequence, stop in the next delay
  task automatic t_run();
    @(posedge clk);
    meas_result <= 32'h4000_1234;
    meas_done   <= 1'b1;
    u_host.pulse(1'b0);
    wait_meas(1'b1, n);
    check("delay", near(n, DELAY_CYC), 1);
    check("hold", scl_hold, 1);
    wait_meas(1'b0, n);
    check("length", n, MEAS_CYC);
    check("result", last_result, 32'h4000_1234);
    check("rerun", asleep, 0);
    @(posedge clk);
    meas_done <= 1'b0;
    u_host.pulse(1'b1);
    repeat (3) @(negedge clk);
    check("slept", asleep, 1);
    repeat (600) @(negedge clk);
    check("no run", measuring, 0);
    check("kept", last_result, 32'h4000_1234);
    check("jumper idle", jumper_seen, 0);
  endtask

  // Jumper start; stop and a one-cycle result inside measurement
  task automatic t_jumper();
    @(posedge clk);
    start_jumper <= 1'b1;
    wait_meas(1'b1, n);
    check("jumper delay", near(n, DELAY_CYC), 1);
    @(posedge clk);
    meas_result <= 32'h8000_0055;
    meas_done   <= 1'b1;
    u_host.stop_early();
    meas_done   <= 1'b0;
    wait_meas(1'b0, n);
    // One cycle of the sequence passed before the stop was taken
    check("finished", n, MEAS_CYC - 1);
    check("new result", last_result, 32'h8000_0055);
    repeat (3) @(negedge clk);
    check("slept early", asleep, 1);
    repeat (3 * TB_TPS * TB_TICK) @(negedge clk);
    check("jumper high", jumper_seen, 1);
  endtask

  // Alarm level, then PWM duty from the stored concentration
  task automatic t_output();
    @(posedge clk);
    alarm <= 1'b1;
    repeat (3) @(negedge clk);
    check("alarm on", oc_oe, 1);
    @(posedge clk);
    alarm <= 1'b0;
    repeat (3) @(negedge clk);
    check("alarm off", oc_oe, 0);
    @(posedge clk);
    pwm_mode <= 1'b1;
    repeat (4) @(negedge clk);
    n = 0;
    repeat (256)
    begin
      @(negedge clk);
      n += oc_oe;
    end
    // Top byte of the stored concentration is 80 hex
    check("duty", n, 128);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    fail_count   = 0;
    cmp_count    = 0;
    rst_n        = 1'b0;
    start_jumper = 1'b0;
    pwm_mode     = 1'b0;
    alarm        = 1'b0;
    meas_done    = 1'b0;
    meas_result  = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_sleep();
    t_run();
    t_jumper();
    t_output();
    final_report();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
